//--- src/mdb_pkg.sv
// Shared constants, state codes and the CRC step for the Modbus RTU reader.
// Assumes a 10 MHz core clock; every user imports nothing and writes mdb_pkg::name.
package mdb_pkg;

    // Clock and character timing
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned BAUD_RATE       = 19200;           // Bits per second
    localparam int unsigned DATA_BITS       = 8;               // No parity bit
    localparam int unsigned STOP_BITS       = 1;
    localparam int unsigned BIT_CYCLES      = (CLK_HZ + BAUD_RATE / 2) / BAUD_RATE;
    localparam int unsigned HALF_BIT_CYCLES = BIT_CYCLES / 2;
    localparam int unsigned CHAR_BITS       = 1 + DATA_BITS + STOP_BITS;

    // Gaps kept by the master, in milliseconds
    localparam int unsigned BYTE_GAP_MS     = 20;              // Longest gap inside a request
    localparam int unsigned FRAME_GAP_MS    = 50;              // Least gap between requests
    localparam int unsigned BYTE_GAP_CYCLES = BYTE_GAP_MS * (CLK_HZ / 1000);

    // Protocol values
    localparam logic [7:0]  FUNC_READ_HOLD  = 8'h03;
    localparam logic [3:0]  REQ_BYTES       = 4'h8;            // Addr, func, 2 start, 2 count, 2 CRC
    localparam logic [15:0] CRC_INIT        = 16'hffff;
    localparam logic [15:0] CRC_POLY        = 16'ha001;        // Reflected CRC-16 polynomial
    localparam logic [15:0] MAX_COUNT       = 16'h007d;        // Byte count must fit one byte
    localparam logic [7:0]  FACTORY_ADDR    = 8'h01;           // Arbitrary default slave address

    // Holding register map, zero based
    localparam logic [15:0] NUM_REGS        = 16'h0010;
    localparam logic [15:0] REG_EPOCH_HI    = 16'h0004;
    localparam logic [15:0] REG_EPOCH_LO    = 16'h0005;
    localparam logic [15:0] REG_SYS_STATUS  = 16'h0007;
    localparam logic [15:0] REG_VISUAL      = 16'h0009;
    localparam logic [15:0] REG_MOTOR_SPEED = 16'h000a;
    localparam logic [15:0] REG_MOTOR_DIR   = 16'h000b;

    // Frame engine states
    typedef enum logic [1:0] {
        ST_LISTEN = 2'b01,
        ST_REPLY  = 2'b10
    } mdb_state_e;

    // One byte through the Modbus CRC, least significant bit first
    function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
        logic [15:0] c;
        c = crc ^ {8'h00, data};
        for (int i = 0; i < 8; i++)
        begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : crc_step

endpackage : mdb_pkg

//--- src/mdb_buf2.sv
// Two-entry byte buffer between the reply builder and the serial sender.
// Assumes one clock, a synchronous active-low reset and a shared clock enable.
`timescale 1ns/1ps
module mdb_buf2 #(
    parameter int unsigned WIDTH = 8
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             resetn,
    input  wire logic             ce,
    // Filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] slot_q [2];   // Storage, read straight from flops
    logic             wr_q;         // Slot for the next write
    logic             rd_q;         // Slot for the next read
    logic [1:0]       cnt_q;        // Words held, 0 to 2
    logic             push;
    logic             pop;

    // Honest full and empty flags
    assign in_ready  = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data  = slot_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointers and count; simultaneous push and pop keep the count
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            wr_q      <= 1'b0;
            rd_q      <= 1'b0;
            cnt_q     <= 2'h0;
            slot_q[0] <= '0;
            slot_q[1] <= '0;
        end
        else if (ce)
        begin
            if (push)
            begin
                slot_q[wr_q] <= in_data;
                wr_q         <= !wr_q;
            end
            if (pop)
            begin
                rd_q <= !rd_q;
            end
            cnt_q <= cnt_q + 2'(push) - 2'(pop);
        end
    end

endmodule : mdb_buf2

//--- src/mdb_rtu_reader.sv
// Modbus RTU slave that answers read-holding-register requests on a serial line.
// Assumes rx_pin is already synchronous to core_clk and idles high.
`timescale 1ns/1ps
module mdb_rtu_reader #(
    parameter int unsigned GAP_CYCLES = mdb_pkg::BYTE_GAP_CYCLES
) (
    // Clock, reset, freeze
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    // Serial line
    input  wire logic        rx_pin,
    output logic             tx_pin,
    // Slave address setting
    input  wire logic        addr_wr,
    input  wire logic [7:0]  addr_wr_data,
    output logic      [7:0]  slave_addr,
    // Register contents from the controller
    input  wire logic [31:0] epoch_secs,
    input  wire logic [15:0] sys_status,
    input  wire logic [15:0] visual_status,
    input  wire logic [15:0] motor_speed,
    input  wire logic [15:0] motor_dir,
    // Activity
    output logic             reply_active
);
    localparam int unsigned CW = 10;                    // Bit-time counter width
    localparam int unsigned GW = 24;                    // Gap counter width

    // Receiver state
    logic [CW-1:0]  rx_cnt_q;                           // Cycles to next sample
    logic [3:0]     rx_bit_q;                           // 0 start, 1-8 data, 9 stop
    logic           rx_busy_q;
    logic [7:0]     rx_shift_q;
    logic           rx_done_q;                          // One-cycle byte strobe
    // Frame collection
    mdb_pkg::mdb_state_e state_q;
    logic [3:0]     nbytes_q;                           // Saturates at 15
    logic [15:0]    rx_crc_q;                           // Zero after a good frame
    logic [GW-1:0]  gap_q;                              // Silence since last byte
    logic [7:0]     req_addr_q;
    logic [7:0]     req_func_q;
    logic [15:0]    req_start_q;
    logic [15:0]    req_count_q;
    logic [7:0]     slave_addr_q;
    // Reply builder
    logic [8:0]     idx_q;                              // Byte index in the reply
    logic [15:0]    tx_crc_q;
    // Sender
    logic [CW-1:0]  tx_cnt_q;
    logic [3:0]     tx_bit_q;
    logic           tx_busy_q;
    logic [9:0]     tx_shift_q;                         // Stop, data, start
    // Buffer wires
    logic           buf_in_valid;
    logic           buf_in_ready;
    logic [7:0]     buf_in_data;
    logic           buf_out_valid;
    logic           buf_out_ready;
    logic [7:0]     buf_out_data;

    // Frame decode
    logic           frame_end;
    logic           frame_ok;
    logic [16:0]    span;
    logic [8:0]     data_idx;
    logic [15:0]    reg_sel;
    logic [15:0]    reg_word;
    logic [8:0]     crc_lo_idx;
    logic           push;

    // End of frame once the line has been quiet for the byte gap
    assign frame_end = (state_q == mdb_pkg::ST_LISTEN) && (nbytes_q != 4'h0)
                       && !rx_busy_q && (gap_q == GW'(GAP_CYCLES - 1));
    assign span      = {1'b0, req_start_q} + {1'b0, req_count_q};
    // Length, address, function, CRC and range all must hold
    assign frame_ok  = (nbytes_q == mdb_pkg::REQ_BYTES) && (rx_crc_q == 16'h0000)
                       && (req_addr_q == slave_addr_q)
                       && (req_func_q == mdb_pkg::FUNC_READ_HOLD)
                       && (req_count_q != 16'h0000) && (req_count_q <= mdb_pkg::MAX_COUNT)
                       && (span <= {1'b0, mdb_pkg::NUM_REGS});

    // Register selection, zero based from the start field
    assign data_idx   = idx_q - 9'h003;
    assign reg_sel    = req_start_q + {8'h00, data_idx[8:1]};
    assign reg_word   = (reg_sel == mdb_pkg::REG_EPOCH_HI)    ? epoch_secs[31:16] :
                        (reg_sel == mdb_pkg::REG_EPOCH_LO)    ? epoch_secs[15:0]  :
                        (reg_sel == mdb_pkg::REG_SYS_STATUS)  ? sys_status        :
                        (reg_sel == mdb_pkg::REG_VISUAL)      ? visual_status     :
                        (reg_sel == mdb_pkg::REG_MOTOR_SPEED) ? motor_speed       :
                        (reg_sel == mdb_pkg::REG_MOTOR_DIR)   ? motor_dir         : 16'h0000;
    assign crc_lo_idx = 9'h003 + {req_count_q[7:0], 1'b0};

    // Reply byte at the current index; high byte of each word first
    assign buf_in_data = (idx_q == 9'h000) ? slave_addr_q :
                         (idx_q == 9'h001) ? mdb_pkg::FUNC_READ_HOLD :
                         (idx_q == 9'h002) ? {req_count_q[6:0], 1'b0} :
                         (idx_q == crc_lo_idx) ? tx_crc_q[7:0] :
                         (idx_q > crc_lo_idx) ? tx_crc_q[15:8] :
                         (data_idx[0] ? reg_word[7:0] : reg_word[15:8]);
    assign buf_in_valid = (state_q == mdb_pkg::ST_REPLY);
    assign push         = buf_in_valid && buf_in_ready;
    assign slave_addr   = slave_addr_q;
    assign reply_active = (state_q == mdb_pkg::ST_REPLY) || buf_out_valid || tx_busy_q;
    assign tx_pin       = tx_shift_q[0];
    assign buf_out_ready = !tx_busy_q;

    // Receiver: centre-sample start, eight data bits, then check stop
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            rx_cnt_q   <= '0;
            rx_bit_q   <= 4'h0;
            rx_busy_q  <= 1'b0;
            rx_shift_q <= 8'h00;
            rx_done_q  <= 1'b0;
        end
        else if (ce)
        begin
            rx_done_q <= 1'b0;
            if (!rx_busy_q)
            begin
                if (!rx_pin)                            // Falling edge of start
                begin
                    rx_busy_q <= 1'b1;
                    rx_bit_q  <= 4'h0;
                    rx_cnt_q  <= CW'(mdb_pkg::HALF_BIT_CYCLES - 1);
                end
            end
            else if (rx_cnt_q != '0)
            begin
                rx_cnt_q <= rx_cnt_q - CW'(1);
            end
            else
            begin
                rx_cnt_q <= CW'(mdb_pkg::BIT_CYCLES - 1);
                if (rx_bit_q == 4'h0)
                begin
                    // A start bit gone high at mid-bit was noise
                    rx_busy_q <= !rx_pin;
                    rx_bit_q  <= 4'h1;
                end
                else if (rx_bit_q <= 4'(mdb_pkg::DATA_BITS))
                begin
                    rx_shift_q <= {rx_pin, rx_shift_q[7:1]};       // LSB first
                    rx_bit_q   <= rx_bit_q + 4'h1;
                end
                else
                begin
                    // Framing error drops the byte; the gap still ends the frame
                    rx_busy_q <= 1'b0;
                    rx_done_q <= rx_pin;
                end
            end
        end
    end

    // Frame collection and reply sequencing
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            state_q      <= mdb_pkg::ST_LISTEN;
            nbytes_q     <= 4'h0;
            rx_crc_q     <= mdb_pkg::CRC_INIT;
            gap_q        <= '0;
            req_addr_q   <= 8'h00;
            req_func_q   <= 8'h00;
            req_start_q  <= 16'h0000;
            req_count_q  <= 16'h0000;
            slave_addr_q <= mdb_pkg::FACTORY_ADDR;
            idx_q        <= 9'h000;
            tx_crc_q     <= mdb_pkg::CRC_INIT;
        end
        else if (ce)
        begin
            // Stored address, rewritable in the field
            if (addr_wr)
            begin
                slave_addr_q <= addr_wr_data;
            end
            // Silence counter restarts on every line activity
            if (rx_busy_q || rx_done_q || nbytes_q == 4'h0)
            begin
                gap_q <= '0;
            end
            else if (gap_q != GW'(GAP_CYCLES - 1))
            begin
                gap_q <= gap_q + GW'(1);
            end
            case (state_q)
                mdb_pkg::ST_LISTEN:
                begin
                    if (frame_end)
                    begin
                        nbytes_q <= 4'h0;
                        rx_crc_q <= mdb_pkg::CRC_INIT;
                        idx_q    <= 9'h000;
                        tx_crc_q <= mdb_pkg::CRC_INIT;
                        // Anything else is dropped without a word
                        if (frame_ok)
                        begin
                            state_q <= mdb_pkg::ST_REPLY;
                        end
                    end
                    else if (rx_done_q)
                    begin
                        rx_crc_q <= mdb_pkg::crc_step(rx_crc_q, rx_shift_q);
                        if (nbytes_q != 4'hf)
                        begin
                            nbytes_q <= nbytes_q + 4'h1;
                        end
                        // Fields in the order they arrive
                        case (nbytes_q)
                            4'h0: req_addr_q         <= rx_shift_q;
                            4'h1: req_func_q         <= rx_shift_q;
                            4'h2: req_start_q[15:8]  <= rx_shift_q;
                            4'h3: req_start_q[7:0]   <= rx_shift_q;
                            4'h4: req_count_q[15:8]  <= rx_shift_q;
                            4'h5: req_count_q[7:0]   <= rx_shift_q;
                            default: ;
                        endcase
                    end
                end
                mdb_pkg::ST_REPLY:
                begin
                    // Bytes heard while answering are ignored: half duplex
                    if (push)
                    begin
                        idx_q <= idx_q + 9'h001;
                        if (idx_q < crc_lo_idx)
                        begin
                            tx_crc_q <= mdb_pkg::crc_step(tx_crc_q, buf_in_data);
                        end
                        if (idx_q > crc_lo_idx)
                        begin
                            state_q <= mdb_pkg::ST_LISTEN;
                        end
                    end
                end
                default:
                begin
                    state_q <= mdb_pkg::ST_LISTEN;
                end
            endcase
        end
    end

    // Stall point: the builder waits while both slots are full
    mdb_buf2 #(
        .WIDTH (8)
    ) u_buf (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .ce        (ce),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   (buf_in_data),
        .out_valid (buf_out_valid),
        .out_ready (buf_out_ready),
        .out_data  (buf_out_data)
    );

    // Sender: start bit, eight data bits LSB first, one stop bit
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            tx_cnt_q   <= '0;
            tx_bit_q   <= 4'h0;
            tx_busy_q  <= 1'b0;
            tx_shift_q <= 10'h3ff;                              // Line idles high
        end
        else if (ce)
        begin
            if (!tx_busy_q)
            begin
                if (buf_out_valid)
                begin
                    tx_shift_q <= {1'b1, buf_out_data, 1'b0};
                    tx_busy_q  <= 1'b1;
                    tx_bit_q   <= 4'h0;
                    tx_cnt_q   <= CW'(mdb_pkg::BIT_CYCLES - 1);
                end
            end
            else if (tx_cnt_q != '0)
            begin
                tx_cnt_q <= tx_cnt_q - CW'(1);
            end
            else
            begin
                tx_cnt_q   <= CW'(mdb_pkg::BIT_CYCLES - 1);
                tx_shift_q <= {1'b1, tx_shift_q[9:1]};
                tx_bit_q   <= tx_bit_q + 4'h1;
                if (tx_bit_q == 4'(mdb_pkg::CHAR_BITS - 1))
                begin
                    tx_busy_q <= 1'b0;
                end
            end
        end
    end

    // Checks on the reply and frame handling
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_push_at(logic [8:0] n);
        ce && push && (idx_q == n);
    endsequence
    sequence s_bad_frame;
        ce && frame_end && !frame_ok;
    endsequence

    reply_addr_a: assert property (s_push_at(9'h000) |-> buf_in_data == slave_addr_q)
        else $error("reply address byte wrong");
    reply_func_a: assert property (s_push_at(9'h001) |-> buf_in_data == 8'h03)
        else $error("reply function byte wrong");
    byte_count_a: assert property (s_push_at(9'h002) |-> buf_in_data == 8'(2 * req_count_q))
        else $error("reply byte count wrong");
    first_word_a: assert property (s_push_at(9'h003) |-> reg_sel == req_start_q)
        else $error("first word not at start index");
    epoch_split_a: assert property (((reg_sel == 16'h0005) |-> reg_word == epoch_secs[15:0])
        and ((reg_sel == 16'h0004) |-> reg_word == epoch_secs[31:16]))
        else $error("epoch words misplaced");
    status_word_a: assert property ((reg_sel == 16'h0007) |-> reg_word == sys_status)
        else $error("status register wrong");
    motor_speed_a: assert property ((reg_sel == 16'h000a) |-> reg_word == motor_speed)
        else $error("motor speed register wrong");
    silent_drop_a: assert property (s_bad_frame |=> state_q == mdb_pkg::ST_LISTEN && !push)
        else $error("bad frame answered");
    good_start_a: assert property (ce && frame_end && frame_ok |=> state_q == mdb_pkg::ST_REPLY
        && idx_q == 9'h000)
        else $error("good frame not answered");
    slave_only_a: assert property ($rose(state_q == mdb_pkg::ST_REPLY) |->
        $past(frame_end && frame_ok))
        else $error("reply without a request");
    addr_store_a: assert property (ce && addr_wr |=> slave_addr_q == $past(addr_wr_data))
        else $error("slave address not stored");
    line_idle_a: assert property (!tx_busy_q |-> tx_pin)
        else $error("line not idle high");
    stop_bit_a: assert property (tx_busy_q && tx_bit_q == 4'h9 |-> tx_pin)
        else $error("stop bit low");

endmodule : mdb_rtu_reader

//--- dv/mdb_master_model.sv
// Serial master model: sends request characters, collects reply characters.
// Assumes 8N1 framing at the package bit time on a line that idles high.
`timescale 1ns/1ps
module mdb_master_model (
    // Clock
    input  wire logic core_clk,
    // Serial line
    input  wire logic tx_pin,
    output logic      rx_pin
);
    logic [7:0] got_q[$];   // Reply bytes in arrival order
    int         bad_stop;   // Reply characters with a low stop bit

    // Line rests at mark, so the device never sees a false start
    initial
    begin
        rx_pin   = 1'b1;
        bad_stop = 0;
    end

    // One character LSB first, then idle cycles before the next
    task automatic send_byte(input logic [7:0] b, input int idle);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(negedge core_clk);
            rx_pin = f[i];
            repeat (mdb_pkg::BIT_CYCLES - 1) @(negedge core_clk);
        end
        repeat (idle) @(negedge core_clk);
    endtask : send_byte

    // Mid-bit sampling of each reply character
    initial
    forever
    begin : rx_char
        logic [7:0] b;
        @(negedge tx_pin);
        repeat (mdb_pkg::HALF_BIT_CYCLES) @(posedge core_clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (mdb_pkg::BIT_CYCLES) @(posedge core_clk);
            b[i] = tx_pin;
        end
        repeat (mdb_pkg::BIT_CYCLES) @(posedge core_clk);
        if (tx_pin !== 1'b1)
            bad_stop++;
        got_q.push_back(b);
    end
endmodule : mdb_master_model

//--- dv/modbus_rtu_register_reader_tb_top.sv
// Bench top: reset, address setting, short-frame discard, two-register read.
// Assumes a shortened frame gap; one request at a time, as a polling master does.
`timescale 1ns/1ps
module modbus_rtu_register_reader_tb_top;
    localparam int unsigned GAP       = 1200;   // Shortened 20 ms gap
    localparam int unsigned FRAME_GAP = 3000;   // Same scale: 50 ms between requests
    localparam int          LIMIT     = 100000; // Cycle ceiling for the run
    logic        core_clk;
    logic        resetn;
    logic        ce;
    logic        rx_pin;
    logic        tx_pin;
    logic        addr_wr;
    logic [7:0]  addr_wr_data;
    logic [7:0]  slave_addr;
    logic [31:0] epoch_secs;
    logic [15:0] sys_status;
    logic [15:0] visual_status;
    logic [15:0] motor_speed;
    logic [15:0] motor_dir;
    logic        reply_active;
    int          err_count;
    int          comparisons;
    int          cycles;

    mdb_rtu_reader #(.GAP_CYCLES(GAP)) mdb_rtu_reader_inst (
        .core_clk(core_clk), .resetn(resetn), .ce(ce), .rx_pin(rx_pin), .tx_pin(tx_pin),
        .addr_wr(addr_wr), .addr_wr_data(addr_wr_data), .slave_addr(slave_addr),
        .epoch_secs(epoch_secs), .sys_status(sys_status), .visual_status(visual_status),
        .motor_speed(motor_speed), .motor_dir(motor_dir), .reply_active(reply_active));

    mdb_master_model mdb_master_model_inst (
        .core_clk(core_clk), .tx_pin(tx_pin), .rx_pin(rx_pin));

    // 10 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Hang guard: fails the run at LIMIT cycles; the reply waits in test_read are already bounded
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            err_count++;
            $display("unexpected at %0t: run too long", $time);
            wrap_up();
        end
    end

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // Bench's own CRC, kept apart from the design's helper
    function automatic logic [15:0] crc16(input logic [7:0] m[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (m[i])
        begin
            c = c ^ {8'h00, m[i]};
            for (int k = 0; k < 8; k++)
                c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
        end
        return c;
    endfunction : crc16

    task automatic test_reset();
        check(32'(tx_pin), 32'h0000_0001, "idle tx");
        check(32'(slave_addr), 32'h0000_0001, "factory address");
        check(32'(reply_active), 32'h0000_0000, "no reply");
        $display("test_reset done");
    endtask : test_reset

    task automatic test_addr_write();
        ce           = 1'b0;
        addr_wr      = 1'b1;
        addr_wr_data = 8'h33;
        @(negedge core_clk);
        check(32'(slave_addr), 32'h0000_0001, "frozen address");
        ce           = 1'b1;
        addr_wr_data = 8'h5a;
        @(negedge core_clk);
        addr_wr = 1'b0;
        check(32'(slave_addr), 32'h0000_005a, "new address");
        $display("test_addr_write done");
    endtask : test_addr_write

    // One lone byte, then silence: must end the frame and be dropped
    task automatic test_short_frame();
        int n;
        n = 0;
        mdb_master_model_inst.send_byte(8'h5a, 0);
        repeat (FRAME_GAP)
        begin
            @(negedge core_clk);
            if (tx_pin !== 1'b1 || reply_active !== 1'b0)
                n++;
        end
        check(n, 0, "silent discard");
        check(mdb_master_model_inst.got_q.size(), 0, "no reply bytes");
        $display("test_short_frame done");
    endtask : test_short_frame

    // Read registers 4 and 5 with one slow inter-byte gap
    task automatic test_read();
        logic [7:0]  req[$];
        logic [7:0]  exp[$];
        logic [15:0] c;
        int          n;
        req = '{8'h5a, 8'h03, 8'h00, 8'h04, 8'h00, 8'h02};
        c   = crc16(req);
        req.push_back(c[7:0]);
        req.push_back(c[15:8]);
        foreach (req[i])
            mdb_master_model_inst.send_byte(req[i], (i == 3) ? 600 : 0);
        n = 0;
        while (reply_active !== 1'b1 && n < GAP + 100)
        begin
            @(negedge core_clk);
            n++;
        end
        check(32'(reply_active), 32'h0000_0001, "reply started");
        n = 0;
        while (reply_active !== 1'b0 && n < 48000)
        begin
            @(negedge core_clk);
            n++;
        end
        exp = '{8'h5a, 8'h03, 8'h04, 8'h65, 8'h43, 8'h21, 8'hfe};
        c   = crc16(exp);
        exp.push_back(c[7:0]);
        exp.push_back(c[15:8]);
        check(mdb_master_model_inst.got_q.size(), 9, "reply length");
        foreach (exp[i])
            if (i < mdb_master_model_inst.got_q.size())
                check(32'(mdb_master_model_inst.got_q[i]), 32'(exp[i]), "reply byte");
        check(mdb_master_model_inst.bad_stop, 0, "stop bits");
        check(32'(tx_pin), 32'h0000_0001, "idle after reply");
        $display("test_read done");
    endtask : test_read

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    // Main sequence
    initial
    begin
        err_count     = 0;
        comparisons   = 0;
        cycles        = 0;
        resetn        = 1'b0;
        ce            = 1'b1;
        addr_wr       = 1'b0;
        addr_wr_data  = 8'h00;
        epoch_secs    = 32'h6543_21fe;
        sys_status    = 16'h0000;
        visual_status = 16'h0020;
        motor_speed   = 16'h1f40;
        motor_dir     = 16'h0001;
        repeat (4) @(negedge core_clk);
        resetn = 1'b1;
        @(negedge core_clk);
        test_reset();
        test_addr_write();
        test_short_frame();
        test_read();
        wrap_up();
    end
endmodule : modbus_rtu_register_reader_tb_top
